// ---- pkg/ida_regs.svh ----
// register offsets, field values and fixed counts of the distributor banks
`ifndef IDA_REGS_SVH
`define IDA_REGS_SVH
`define IDA_OFF_DEACT 12'h380
`define IDA_OFF_PRIO 12'h400
`define IDA_OFF_TGT 12'h800
`define IDA_OFF_END 12'hc00
`define IDA_PRIV_IRQS 32
`define IDA_IRQS_PER_GROUP 32
`define IDA_PRIV_TGT_REGS 8
`define IDA_PRIO_RST 8'h00
`define IDA_TGT_RST 8'h00
`define IDA_NS_PRIO_TOP 8'h80
`define IDA_PROT_NS_BIT 1
`define IDA_RESP_OKAY 2'b00
`define IDA_RESP_DECERR 2'b11
`endif

// ---- pkg/ida_pkg.sv ----
// types shared by the distributor register logic
package ida_pkg;
  typedef enum logic [1:0] {
    IDA_BANK_NONE,
    IDA_BANK_DEACT,
    IDA_BANK_PRIO,
    IDA_BANK_TGT
  } ida_bank_e;
  typedef struct packed {
    logic [11:0] addr;
    logic ns;
    logic [2:0] cpu;
  } ida_req_s;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } ida_wdat_s;
endpackage

// ---- hdl/ida_rank.sv ----
// picks the eligible interrupt with the numerically lowest priority value
`timescale 1ns/10ps
module ida_rank #(
  parameter int N = 64,
  parameter int IDW = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] elig_i,
  input wire logic [N*8-1:0] prio_i,
  output logic vld_o,
  output logic [IDW-1:0] id_o,
  output logic [7:0] prio_o
);
  logic found;
  logic better;
  logic [IDW-1:0] best_id;
  logic [7:0] best_p;

  // strict compare keeps the lowest id on a tie
  always_comb begin
    found = 1'b0;
    best_id = '0;
    best_p = 8'hff;
    for (int i = 0; i < N; i++) begin
      if (elig_i[i] && (!found || prio_i[8*i +: 8] < best_p)) begin
        found = 1'b1;
        best_id = IDW'(i);
        best_p = prio_i[8*i +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      vld_o <= 1'b0;
      id_o <= '0;
      prio_o <= 8'h00;
    end else begin
      vld_o <= found;
      id_o <= best_id;
      prio_o <= best_p;
    end
  end

  always_comb begin
    better = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (elig_i[i] && prio_i[8*i +: 8] < best_p) better = 1'b1;
    end
  end

  property p_rank_min;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    found |-> !better;
  endproperty
  a_rank_min: assert property (p_rank_min) else $error("a lower priority value was passed over");
endmodule

// ---- hdl/ida_dist.sv ----
// active, priority and target banks of the interrupt distributor, AXI4-Lite slave
`timescale 1ns/10ps
`include "ida_regs.svh"
//////////////////////////////////////////////////////////////////////////////
module ida_dist import ida_pkg::*; #(
  parameter int LINE_GROUPS = 1,
  parameter int NUM_CPUS = 2,
  parameter int PRIO_BITS = 8,
  parameter bit SEC_EXT = 1'b1,
  parameter int LOCK_SPIS = 31,
  parameter logic [1023:0] FIXED_MASK = '0,
  parameter logic [7:0] FIXED_TGT = 8'h01,
  localparam int NUM_IRQ = `IDA_IRQS_PER_GROUP * (LINE_GROUPS + 1),
  localparam int NSPI = NUM_IRQ - `IDA_PRIV_IRQS,
  localparam int ACT_W = NUM_CPUS * `IDA_PRIV_IRQS + NSPI,
  localparam int ID_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic [2:0] s_axi_awuser_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic [2:0] s_axi_aruser_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_IRQ-1:0] grp1_i,
  input wire logic lock_i,
  input wire logic [ACT_W-1:0] act_set_i,
  input wire logic [ACT_W-1:0] pend_i,
  output logic [ACT_W-1:0] active_o,
  output logic [NUM_CPUS-1:0] best_vld_o,
  output logic [NUM_CPUS*ID_W-1:0] best_id_o,
  output logic [NUM_CPUS*8-1:0] best_prio_o
);
  localparam logic [7:0] PMASK = 8'(8'hff << (8 - PRIO_BITS));
  localparam logic [7:0] CPU_MASK = 8'((9'h001 << NUM_CPUS) - 9'h001);

  if (LINE_GROUPS < 1 || LINE_GROUPS > 31 || NUM_CPUS < 1 || NUM_CPUS > 8 ||
      PRIO_BITS < 4 || PRIO_BITS > 8) begin : g_bad_cfg
    $error("ida_dist: unsupported configuration");
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [ACT_W-1:0] act_r;
  logic [ACT_W-1:0] clr_vec;
  logic [7:0] prio_r [ACT_W];
  logic [7:0] tgt_r [NSPI];
  logic aw_held_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  ida_req_s wreq_r;
  ida_wdat_s wdat_r;
  logic wr_go;
  logic ar_hs;
  ida_bank_e wr_bank;
  ida_bank_e ar_bank;
  int wr_n;
  int ar_n;
  logic ar_ns;
  logic [31:0] rd_word;

  function automatic ida_bank_e bank_of(input logic [11:0] a);
    if (a >= `IDA_OFF_DEACT && a < `IDA_OFF_PRIO) return IDA_BANK_DEACT;
    if (a >= `IDA_OFF_PRIO && a < `IDA_OFF_TGT) return IDA_BANK_PRIO;
    if (a >= `IDA_OFF_TGT && a < `IDA_OFF_END) return IDA_BANK_TGT;
    return IDA_BANK_NONE;
  endfunction

  function automatic int word_of(input logic [11:0] a);
    case (bank_of(a))
      IDA_BANK_DEACT: return int'(a[11:2]) - int'(`IDA_OFF_DEACT >> 2);
      IDA_BANK_PRIO: return int'(a[11:2]) - int'(`IDA_OFF_PRIO >> 2);
      IDA_BANK_TGT: return int'(a[11:2]) - int'(`IDA_OFF_TGT >> 2);
      default: return 0;
    endcase
  endfunction

  // private interrupts get one slot per processor, shared ones a single slot
  function automatic int slot(input logic [2:0] cpu, input int m);
    if (m < `IDA_PRIV_IRQS) return int'(cpu) * `IDA_PRIV_IRQS + m;
    return NUM_CPUS * `IDA_PRIV_IRQS + m - `IDA_PRIV_IRQS;
  endfunction

  // unimplemented ids, missing banks and non-secure group 0 are all invisible
  function automatic logic vis(input logic [2:0] cpu, input logic ns, input int m);
    if (m >= NUM_IRQ) return 1'b0;
    if (m < `IDA_PRIV_IRQS && int'(cpu) >= NUM_CPUS) return 1'b0;
    return !(ns && !grp1_i[m]);
  endfunction

  function automatic logic locked(input int m);
    return lock_i && SEC_EXT && !grp1_i[m] && m >= `IDA_PRIV_IRQS &&
           m < `IDA_PRIV_IRQS + LOCK_SPIS;
  endfunction

  function automatic logic tgt_hit(input int c, input int m);
    if (m < `IDA_PRIV_IRQS || NUM_CPUS == 1) return 1'b1;
    if (FIXED_MASK[m]) return FIXED_TGT[c];
    return tgt_r[m - `IDA_PRIV_IRQS][c];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // write channels are taken independently; the write happens once both are held
  assign s_axi_awready_o = !aw_held_r;
  assign s_axi_wready_o = !w_held_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_bank = bank_of(wreq_r.addr);
  assign wr_n = word_of(wreq_r.addr);
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      wreq_r <= '0;
    end else if (s_axi_awvalid_i && !aw_held_r) begin
      aw_held_r <= 1'b1;
      wreq_r <= '{s_axi_awaddr_i, SEC_EXT && s_axi_awprot_i[`IDA_PROT_NS_BIT], s_axi_awuser_i};
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      w_held_r <= 1'b0;
      wdat_r <= '0;
    end else if (s_axi_wvalid_i && !w_held_r) begin
      w_held_r <= 1'b1;
      wdat_r <= '{s_axi_wdata_i, s_axi_wstrb_i};
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `IDA_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_bank == IDA_BANK_NONE) ? `IDA_RESP_DECERR : `IDA_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // active state; a set arriving with a clear wins
  always_comb begin
    clr_vec = '0;
    if (wr_go && wr_bank == IDA_BANK_DEACT) begin
      for (int b = 0; b < 32; b++) begin
        if (vis(wreq_r.cpu, wreq_r.ns, 32 * wr_n + b) && wdat_r.strb[b/8] &&
            wdat_r.data[b]) begin
          clr_vec[slot(wreq_r.cpu, 32 * wr_n + b)] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) act_r <= '0;
    else act_r <= (act_r & ~clr_vec) | act_set_i;
  end
  assign active_o = act_r;

  // priority fields, lane by lane so byte writes touch only their own field
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ACT_W; i++) prio_r[i] <= `IDA_PRIO_RST;
    end else if (wr_go && wr_bank == IDA_BANK_PRIO) begin
      for (int l = 0; l < 4; l++) begin
        if (wdat_r.strb[l] && vis(wreq_r.cpu, wreq_r.ns, 4 * wr_n + l) &&
            !locked(4 * wr_n + l)) begin
          if (wreq_r.ns) begin
            prio_r[slot(wreq_r.cpu, 4 * wr_n + l)] <=
              (`IDA_NS_PRIO_TOP | (wdat_r.data[8*l +: 8] >> 1)) & PMASK;
          end else begin
            prio_r[slot(wreq_r.cpu, 4 * wr_n + l)] <= wdat_r.data[8*l +: 8] & PMASK;
          end
        end
      end
    end
  end

  // targets of shared interrupts; the private eight registers are read-only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NSPI; i++) tgt_r[i] <= `IDA_TGT_RST;
    end else if (wr_go && wr_bank == IDA_BANK_TGT && NUM_CPUS > 1) begin
      for (int l = 0; l < 4; l++) begin
        if (wdat_r.strb[l] && 4 * wr_n + l >= `IDA_PRIV_IRQS &&
            vis(wreq_r.cpu, wreq_r.ns, 4 * wr_n + l) && !FIXED_MASK[4 * wr_n + l] &&
            !locked(4 * wr_n + l)) begin
          tgt_r[4 * wr_n + l - `IDA_PRIV_IRQS] <= wdat_r.data[8*l +: 8] & CPU_MASK;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel answers one cycle after the address is taken
  assign s_axi_arready_o = !rvalid_r;
  assign ar_hs = s_axi_arvalid_i && !rvalid_r;
  assign ar_bank = bank_of(s_axi_araddr_i);
  assign ar_n = word_of(s_axi_araddr_i);
  assign ar_ns = SEC_EXT && s_axi_arprot_i[`IDA_PROT_NS_BIT];
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;

  always_comb begin
    rd_word = '0;
    case (ar_bank)
      IDA_BANK_DEACT: begin
        for (int b = 0; b < 32; b++) begin
          if (vis(s_axi_aruser_i, ar_ns, 32 * ar_n + b)) begin
            rd_word[b] = act_r[slot(s_axi_aruser_i, 32 * ar_n + b)];
          end
        end
      end
      IDA_BANK_PRIO: begin
        for (int l = 0; l < 4; l++) begin
          if (vis(s_axi_aruser_i, ar_ns, 4 * ar_n + l)) begin
            rd_word[8*l +: 8] = ar_ns ?
              8'((prio_r[slot(s_axi_aruser_i, 4 * ar_n + l)] & PMASK) << 1) :
              prio_r[slot(s_axi_aruser_i, 4 * ar_n + l)] & PMASK;
          end
        end
      end
      IDA_BANK_TGT: begin
        for (int l = 0; l < 4; l++) begin
          if (NUM_CPUS > 1 && vis(s_axi_aruser_i, ar_ns, 4 * ar_n + l)) begin
            if (ar_n < `IDA_PRIV_TGT_REGS) rd_word[8*l +: 8] = 8'(9'h001 << s_axi_aruser_i);
            else if (FIXED_MASK[4 * ar_n + l]) rd_word[8*l +: 8] = FIXED_TGT & CPU_MASK;
            else rd_word[8*l +: 8] = tgt_r[4 * ar_n + l - `IDA_PRIV_IRQS];
          end
        end
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rresp_r <= `IDA_RESP_OKAY;
      rdata_r <= '0;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rresp_r <= (ar_bank == IDA_BANK_NONE) ? `IDA_RESP_DECERR : `IDA_RESP_OKAY;
      rdata_r <= rd_word;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-interface ranking; pending at an interface follows the live target list,
  // so a target change moves pending at once and never touches active state
  for (genvar c = 0; c < NUM_CPUS; c++) begin : g_cpu
    logic [NUM_IRQ-1:0] elig;
    logic [NUM_IRQ*8-1:0] pv;
    always_comb begin
      elig = '0;
      pv = '0;
      for (int m = 0; m < NUM_IRQ; m++) begin
        pv[8*m +: 8] = prio_r[slot(3'(c), m)];
        elig[m] = pend_i[slot(3'(c), m)] && !act_r[slot(3'(c), m)] && tgt_hit(c, m);
      end
    end
    ida_rank #(.N(NUM_IRQ), .IDW(ID_W)) u_rank (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .elig_i(elig),
      .prio_i(pv),
      .vld_o(best_vld_o[c]),
      .id_o(best_id_o[c*ID_W +: ID_W]),
      .prio_o(best_prio_o[c*8 +: 8])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  int wr_m0;
  int wr_s0;
  int ar_m0;
  logic prio_low_or;
  assign wr_m0 = 4 * wr_n;
  assign wr_s0 = slot(wreq_r.cpu, wr_m0);
  assign ar_m0 = 4 * ar_n;
  always_comb begin
    prio_low_or = 1'b0;
    for (int i = 0; i < ACT_W; i++) prio_low_or = prio_low_or | (|(prio_r[i] & ~PMASK));
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_prio_wr0;
    wr_go && wr_bank == IDA_BANK_PRIO && wdat_r.strb[0] && vis(wreq_r.cpu, wreq_r.ns, wr_m0) &&
      !locked(wr_m0);
  endsequence

  property p_deact_clear;
    wr_go && |clr_vec && !(|act_set_i) |=> (active_o & $past(clr_vec)) == '0;
  endproperty
  a_deact_clear: assert property (p_deact_clear) else $error("cleared bit still active");

  property p_act_no_stray_fall;
    1'b1 |=> ($past(act_r) & ~act_r & ~$past(clr_vec)) == '0;
  endproperty
  a_act_no_stray_fall: assert property (p_act_no_stray_fall) else $error("active fell");

  property p_rd_spi0_active;
    ar_hs && s_axi_araddr_i == (`IDA_OFF_DEACT + 12'h004) && !ar_ns
      |=> s_axi_rdata_o[0] == $past(act_r[NUM_CPUS * `IDA_PRIV_IRQS]);
  endproperty
  a_rd_spi0_active: assert property (p_rd_spi0_active) else $error("active read wrong");

  property p_unimpl_raz;
    ar_hs && ar_bank == IDA_BANK_DEACT && ar_n > LINE_GROUPS |=> s_axi_rdata_o == '0;
  endproperty
  a_unimpl_raz: assert property (p_unimpl_raz) else $error("unimplemented bits not zero");

  property p_ns_grp0_prio;
    ar_hs && ar_bank == IDA_BANK_PRIO && ar_ns && ar_m0 < NUM_IRQ && !grp1_i[ar_m0]
      |=> s_axi_rdata_o[7:0] == 8'h00;
  endproperty
  a_ns_grp0_prio: assert property (p_ns_grp0_prio) else $error("group 0 priority leaked");

  property p_sec_prio_wr;
    s_prio_wr0 ##0 !wreq_r.ns |=> prio_r[$past(wr_s0)] == ($past(wdat_r.data[7:0]) & PMASK);
  endproperty
  a_sec_prio_wr: assert property (p_sec_prio_wr) else $error("secure priority write wrong");

  property p_ns_prio_wr;
    s_prio_wr0 ##0 wreq_r.ns
      |=> prio_r[$past(wr_s0)] == ((`IDA_NS_PRIO_TOP | ($past(wdat_r.data[7:0]) >> 1)) & PMASK);
  endproperty
  a_ns_prio_wr: assert property (p_ns_prio_wr) else $error("non-secure priority write wrong");

  property p_prio_byte;
    s_prio_wr0 ##0 wdat_r.strb == 4'h1 |=> prio_r[$past(wr_s0) + 1] == $past(prio_r[wr_s0 + 1]);
  endproperty
  a_prio_byte: assert property (p_prio_byte) else $error("byte write touched next field");

  property p_prio_low;
    !prio_low_or;
  endproperty
  a_prio_low: assert property (p_prio_low) else $error("unkept priority bits set");

  property p_tgt_priv;
    ar_hs && ar_bank == IDA_BANK_TGT && ar_n < `IDA_PRIV_TGT_REGS && !ar_ns && NUM_CPUS > 1 &&
      int'(s_axi_aruser_i) < NUM_CPUS |=> s_axi_rdata_o == {4{8'(9'h001 << $past(s_axi_aruser_i))}};
  endproperty
  a_tgt_priv: assert property (p_tgt_priv) else $error("private target read wrong");

  property p_tgt_single;
    ar_hs && ar_bank == IDA_BANK_TGT && NUM_CPUS == 1 |=> s_axi_rdata_o == '0;
  endproperty
  a_tgt_single: assert property (p_tgt_single) else $error("single processor target not zero");
endmodule

// ---- tb/ida_cpu_model.sv ----
// far-side model: cpu interfaces raising activations and pending lines
`timescale 1ns/10ps
module ida_cpu_model #(
  parameter int ACT_W = 96
) (
  input wire logic ref_clk_i,
  output logic [ACT_W-1:0] act_set_o,
  output logic [ACT_W-1:0] pend_o
);
  initial begin
    act_set_o = '0;
    pend_o = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one-cycle activation, as an acknowledge on a cpu interface gives it
  task automatic activate(input int slot);
    act_set_o[slot] <= 1'b1;
    @(posedge ref_clk_i);
    act_set_o[slot] <= 1'b0;
  endtask
  // pending is a level; the source holds it until it drops the request
  task automatic set_pend(input int slot, input logic v);
    pend_o[slot] <= v;
  endtask
endmodule

// ---- tb/test_ida_dist.sv ----
// self-checking bench for the distributor active, priority and target banks
`timescale 1ns/10ps
`include "ida_regs.svh"
module test_ida_dist;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, awuser = 3'h0, arprot = 3'h0, aruser = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [95:0] act_set, pend, active;
  logic [1:0] best_vld;
  logic [19:0] best_id;
  logic [15:0] best_prio;
  // interrupt 33 is the only group 0 line, and it lies inside the lockable range
  logic [63:0] grp1 = ~64'h0000000200000000;
  logic lock = 1'b0;
  int errors = 0;
  int checks_done = 0;
  always #2.5 ref_clk = ~ref_clk;
  ida_dist dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(awprot), .s_axi_awuser_i(awuser), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(arprot), .s_axi_aruser_i(aruser), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .grp1_i(grp1), .lock_i(lock),
    .act_set_i(act_set), .pend_i(pend), .active_o(active), .best_vld_o(best_vld),
    .best_id_o(best_id), .best_prio_o(best_prio));
  ida_cpu_model #(.ACT_W(96)) cpu (.ref_clk_i(ref_clk), .act_set_o(act_set), .pend_o(pend));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // address and data go out together; each drops at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic ns, input logic [2:0] u, input logic [1:0] er);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    awprot <= {1'b0, ns, 1'b0};
    awuser <= u;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic ns, input logic [2:0] u,
                    input logic [31:0] exp, input logic [1:0] er);
    logic ar_p;
    ar_p = 1'b1;
    araddr <= a;
    arprot <= {1'b0, ns, 1'b0};
    aruser <= u;
    arvalid <= 1'b1;
    // rready rises only once the address is taken, so back-to-back reads never
    // lower and raise it in the same step
    forever begin
      @(posedge ref_clk);
      if (!ar_p && rvalid === 1'b1) break;
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
    rready <= 1'b0;
    chk($sformatf("rdata@%h", a), exp, rdata);
    chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, rresp});
  endtask
  // ranking outputs settle one edge after their inputs; three edges leave margin
  task automatic best(input int c, input logic v, input logic [7:0] p, input logic [9:0] id);
    repeat (3) @(posedge ref_clk);
    chk($sformatf("best cpu%0d", c), {13'h0, v, v ? {p, id} : 18'h0},
        {13'h0, best_vld[c], v ? {best_prio[c*8+:8], best_id[c*10+:10]} : 18'h0});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(`IDA_OFF_PRIO, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    rd(`IDA_OFF_DEACT, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    rd(12'h000, 1'b0, 3'h0, 32'h0, `IDA_RESP_DECERR);
    wr(`IDA_OFF_END, 32'hffffffff, 4'hf, 1'b0, 3'h0, `IDA_RESP_DECERR);
    $display("test reset_decode done");
    cpu.activate(72);
    cpu.activate(5);
    rd(12'h384, 1'b0, 3'h0, 32'h00000100, `IDA_RESP_OKAY);
    wr(12'h384, 32'h0, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h384, 1'b0, 3'h0, 32'h00000100, `IDA_RESP_OKAY);
    wr(12'h384, 32'h00000100, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    chk("active slot 72", 32'h0, {31'h0, active[72]});
    rd(12'h384, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    rd(12'h380, 1'b0, 3'h1, 32'h0, `IDA_RESP_OKAY);
    wr(12'h380, 32'h00000020, 4'hf, 1'b0, 3'h1, `IDA_RESP_OKAY);
    rd(12'h380, 1'b0, 3'h0, 32'h00000020, `IDA_RESP_OKAY);
    wr(12'h380, 32'h00000020, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h380, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    cpu.activate(65);
    rd(12'h384, 1'b1, 3'h0, 32'h0, `IDA_RESP_OKAY);
    wr(12'h384, 32'h00000002, 4'hf, 1'b1, 3'h0, `IDA_RESP_OKAY);
    rd(12'h384, 1'b0, 3'h0, 32'h00000002, `IDA_RESP_OKAY);
    wr(12'h384, 32'h00000002, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h388, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    $display("test deactivate done");
    wr(12'h408, 32'h12345678, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h408, 1'b0, 3'h0, 32'h12345678, `IDA_RESP_OKAY);
    wr(12'h408, 32'h0000ab00, 4'h2, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h408, 1'b0, 3'h0, 32'h1234ab78, `IDA_RESP_OKAY);
    wr(12'h408, 32'h000000cd, 4'h1, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h408, 1'b0, 3'h0, 32'h1234abcd, `IDA_RESP_OKAY);
    wr(12'h420, 32'h44444444, 4'hf, 1'b1, 3'h0, `IDA_RESP_OKAY);
    rd(12'h420, 1'b0, 3'h0, 32'ha2a200a2, `IDA_RESP_OKAY);
    rd(12'h420, 1'b1, 3'h0, 32'h44440044, `IDA_RESP_OKAY);
    lock <= 1'b1;
    wr(12'h420, 32'h00005500, 4'h2, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h420, 1'b0, 3'h0, 32'ha2a200a2, `IDA_RESP_OKAY);
    lock <= 1'b0;
    wr(12'h420, 32'h00005500, 4'h2, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h420, 1'b0, 3'h0, 32'ha2a255a2, `IDA_RESP_OKAY);
    wr(12'h440, 32'hffffffff, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h440, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    $display("test priority done");
    rd(12'h800, 1'b0, 3'h1, 32'h02020202, `IDA_RESP_OKAY);
    wr(12'h804, 32'hffffffff, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h804, 1'b0, 3'h0, 32'h01010101, `IDA_RESP_OKAY);
    wr(12'h820, 32'h03020100, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h820, 1'b0, 3'h0, 32'h03020100, `IDA_RESP_OKAY);
    rd(12'h820, 1'b1, 3'h0, 32'h03020000, `IDA_RESP_OKAY);
    wr(12'h840, 32'hffffffff, 4'hf, 1'b0, 3'h0, `IDA_RESP_OKAY);
    rd(12'h840, 1'b0, 3'h0, 32'h0, `IDA_RESP_OKAY);
    $display("test targets done");
    wr(12'h428, 32'h00002060, 4'h3, 1'b0, 3'h0, `IDA_RESP_OKAY);
    wr(12'h828, 32'h00000101, 4'h3, 1'b0, 3'h0, `IDA_RESP_OKAY);
    cpu.set_pend(72, 1'b1);
    cpu.set_pend(73, 1'b1);
    best(0, 1'b1, 8'h20, 10'd41);
    best(1, 1'b0, 8'h00, 10'd0);
    wr(12'h828, 32'h00000201, 4'h3, 1'b0, 3'h0, `IDA_RESP_OKAY);
    best(0, 1'b1, 8'h60, 10'd40);
    best(1, 1'b1, 8'h20, 10'd41);
    cpu.activate(73);
    best(1, 1'b0, 8'h00, 10'd0);
    wr(12'h828, 32'h00000101, 4'h3, 1'b0, 3'h0, `IDA_RESP_OKAY);
    chk("active slot 73", 32'h1, {31'h0, active[73]});
    best(0, 1'b1, 8'h60, 10'd40);
    $display("test ranking done");
    finish_test;
  end
endmodule
